// file: core/sar_conv_ctrl.sv
// conversion control of an eight-channel simultaneous-sampling 18-bit SAR converter
//
// Functional notes
// - A rising edge on convert_start puts every channel into hold at once and starts a conversion.
// - Channels are tied to the single 18-bit capacitor converter one at a time, in order.
// - Each channel runs an 18-step binary search from half scale down to 1/262144 of scale.
// - Results of all channels are published together only after the last channel is done.
// - Range codes 7, 6, 3 and 2 are bipolar and their results come out in two's complement.
// - Channels on a unipolar range give straight binary results with no sign bit.
// - Each channel has its own range code, which may change and applies to the next conversion.
// - Disabled channels are skipped in one cycle instead of 19, so the whole conversion finishes sooner; each enabled channel still takes 19.
// - The serial port style (CMOS or LVDS) comes from a static strap pin, not from a register.
// - In CMOS mode the serial output uses one to eight lanes, as the host sets them in control register bits 6:4.
// - A power-down state keeps new conversions from starting while it is set; a conversion already running completes.
// - Range codes 5, 4 and 1 are unipolar spans of full, reduced and half reference scale.
// - The eight 3-bit range codes form one 24-bit word that the host writes and the device keeps.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sar_ctrl_params.svh"

module sar_conv_ctrl (
  // clock and reset
  input  wire logic                     I_CLOCK,
  input  wire logic                     I_NRST,
  // converter pins and analog handshake
  input  wire logic                     I_CONVERT_START,
  input  wire logic                     I_LVDS_STRAP,
  input  wire logic                     I_COMP_ABOVE,
  output logic                          O_HOLD,
  output logic                          O_BUSY,
  output logic [2:0]                    O_CHAN_SEL,
  output sar_ctrl_pkg::result_t         O_CAP_REDISTRIBUTION_DAC,
  output logic                          O_LVDS_MODE,
  output logic [3:0]                    O_LANES,
  output logic                          O_POWER_DOWN,
  // axi4-lite slave
  input  wire sar_ctrl_pkg::axi_addr_t  I_AWADDR,
  input  wire logic                     I_AWVALID,
  output logic                          O_AWREADY,
  input  wire sar_ctrl_pkg::axi_data_t  I_WDATA,
  input  wire logic [3:0]               I_WSTRB,
  input  wire logic                     I_WVALID,
  output logic                          O_WREADY,
  output logic [1:0]                    O_BRESP,
  output logic                          O_BVALID,
  input  wire logic                     I_BREADY,
  input  wire sar_ctrl_pkg::axi_addr_t  I_ARADDR,
  input  wire logic                     I_ARVALID,
  output logic                          O_ARREADY,
  output sar_ctrl_pkg::axi_data_t       O_RDATA,
  output logic [1:0]                    O_RRESP,
  output logic                          O_RVALID,
  input  wire logic                     I_RREADY
);
  import sar_ctrl_pkg::*;

  //--------------------------------------------------------------------
  // pin synchronisers and strap capture
  //--------------------------------------------------------------------
  logic [1:0]  start_sync;
  logic        start_prev;
  logic [1:0]  strap_sync;
  logic [1:0]  strap_wait;
  logic        strap_done;
  logic        start_rise;

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      start_sync  <= 2'h0;
      start_prev  <= 1'b0;
      strap_sync  <= 2'h0;
      strap_wait  <= 2'h0;
      strap_done  <= 1'b0;
      O_LVDS_MODE <= 1'b0;
    end else begin
      start_sync <= {start_sync[0], I_CONVERT_START};
      start_prev <= start_sync[1];
      strap_sync <= {strap_sync[0], I_LVDS_STRAP};
      // capture only once the synchroniser holds the pin, not its reset value
      strap_wait <= {strap_wait[0], 1'b1};
      strap_done <= strap_wait[1];
      if (strap_wait[1] && !strap_done) begin
        O_LVDS_MODE <= strap_sync[1];
      end
    end
  end

  assign start_rise = start_sync[1] && !start_prev;

  //--------------------------------------------------------------------
  // register file and conversion state
  //--------------------------------------------------------------------
  axi_data_t    ctrl_reg;
  logic [23:0]  range_word;
  logic [23:0]  conv_range;
  conv_state_t  state;
  logic [4:0]   sar_bit;
  result_t      work [`NUM_CHANNELS];
  result_t      result [`NUM_CHANNELS];

  axi_data_t    next_ctrl_reg;
  logic [23:0]  next_range_word;
  logic [23:0]  next_conv_range;
  conv_state_t  next_state;
  logic [4:0]   next_sar_bit;
  logic [2:0]   next_chan;
  result_t      next_dac;
  result_t      next_work [`NUM_CHANNELS];
  result_t      next_result [`NUM_CHANNELS];
  logic         next_hold;
  range_code_t  cur_range;
  logic         cur_en;
  result_t      kept;
  result_t      fmt;

  //--------------------------------------------------------------------
  // axi4-lite slave
  //--------------------------------------------------------------------
  axi_addr_t  aw_addr;
  axi_data_t  w_data;
  logic [3:0] w_strb;
  axi_addr_t  next_aw_addr;
  axi_data_t  next_w_data;
  logic [3:0] next_w_strb;
  logic       next_awready;
  logic       next_wready;
  logic       next_bvalid;
  logic [1:0] next_bresp;
  logic       next_arready;
  logic       next_rvalid;
  logic [1:0] next_rresp;
  axi_data_t  next_rdata;
  logic       do_write;

  function automatic axi_data_t merge(input axi_data_t old, input axi_data_t nw,
                                      input logic [3:0] strb);
    axi_data_t res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : merge

  function automatic logic is_mapped(input axi_addr_t a);
    return (a == `ADDR_CTRL) || (a == `ADDR_RANGE) || (a == `ADDR_STATUS) ||
           ((a >= `ADDR_RESULT0) && (a <= `ADDR_RESULT_LAST) && (a[1:0] == 2'h0));
  endfunction : is_mapped

  assign do_write = !O_AWREADY && !O_WREADY && !O_BVALID;

  always_comb begin
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_awready = O_AWREADY;
    next_wready  = O_WREADY;
    next_bvalid  = O_BVALID;
    next_bresp   = O_BRESP;
    next_arready = O_ARREADY;
    next_rvalid  = O_RVALID;
    next_rresp   = O_RRESP;
    next_rdata   = O_RDATA;
    if (I_AWVALID && O_AWREADY) begin
      next_aw_addr = I_AWADDR;
      next_awready = 1'b0;
    end
    if (I_WVALID && O_WREADY) begin
      next_w_data = I_WDATA;
      next_w_strb = I_WSTRB;
      next_wready = 1'b0;
    end
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = is_mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
    end
    if (O_BVALID && I_BREADY) begin
      next_bvalid  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
    end
    if (I_ARVALID && O_ARREADY) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = is_mapped(I_ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      next_rdata   = 32'h0000_0000;
      if (I_ARADDR == `ADDR_CTRL) begin
        next_rdata = ctrl_reg;
      end else if (I_ARADDR == `ADDR_RANGE) begin
        next_rdata = {8'h00, range_word};
      end else if (I_ARADDR == `ADDR_STATUS) begin
        next_rdata = {27'h0, O_CHAN_SEL, O_LVDS_MODE, O_BUSY};
      end else if (is_mapped(I_ARADDR) && I_ARADDR >= `ADDR_RESULT0) begin
        next_rdata = {14'h0, result[I_ARADDR[4:2]]};
      end
    end
    if (O_RVALID && I_RREADY) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      aw_addr   <= 8'h00;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      O_AWREADY <= 1'b1;
      O_WREADY  <= 1'b1;
      O_BVALID  <= 1'b0;
      O_BRESP   <= `RESP_OKAY;
      O_ARREADY <= 1'b1;
      O_RVALID  <= 1'b0;
      O_RRESP   <= `RESP_OKAY;
      O_RDATA   <= 32'h0000_0000;
    end else begin
      aw_addr   <= next_aw_addr;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      O_AWREADY <= next_awready;
      O_WREADY  <= next_wready;
      O_BVALID  <= next_bvalid;
      O_BRESP   <= next_bresp;
      O_ARREADY <= next_arready;
      O_RVALID  <= next_rvalid;
      O_RRESP   <= next_rresp;
      O_RDATA   <= next_rdata;
    end
  end

  //--------------------------------------------------------------------
  // conversion sequencer
  //--------------------------------------------------------------------
  always_comb begin
    axi_data_t merged;
    merged = merge({8'h00, range_word}, w_data, w_strb);
    cur_range = conv_range[3*O_CHAN_SEL +: 3];
    cur_en    = (cur_range != 3'h0);
    kept      = I_COMP_ABOVE ? O_CAP_REDISTRIBUTION_DAC
                             : (O_CAP_REDISTRIBUTION_DAC & ~(18'h1 << sar_bit));
    fmt       = is_bipolar(cur_range) ? {~kept[17], kept[16:0]}
                                      : kept;
    next_ctrl_reg   = ctrl_reg;
    next_range_word = range_word;
    if (do_write && aw_addr == `ADDR_CTRL) begin
      next_ctrl_reg = merge(ctrl_reg, w_data, w_strb) & 32'h0000_0071;
    end
    if (do_write && aw_addr == `ADDR_RANGE) begin
      next_range_word = merged[23:0];
    end
    next_state      = state;
    next_sar_bit    = sar_bit;
    next_chan       = O_CHAN_SEL;
    next_dac        = O_CAP_REDISTRIBUTION_DAC;
    next_conv_range = conv_range;
    next_hold       = O_HOLD;
    next_work       = work;
    next_result     = result;
    case (state)
      ST_IDLE: begin
        if (start_rise && !ctrl_reg[`CTRL_PD_BIT]) begin
          next_hold       = 1'b1;
          next_conv_range = range_word;
          next_chan       = 3'h0;
          next_state      = ST_SCAN;
        end
      end
      ST_SCAN: begin
        if (cur_en) begin
          next_dac     = `DAC_MSB_CODE;
          next_sar_bit = 5'd17;
          next_state   = ST_SAR;
        end else begin
          next_work[O_CHAN_SEL] = 18'h0;
          next_chan  = O_CHAN_SEL + 3'h1;
          next_state = (O_CHAN_SEL == 3'h7) ? ST_PUBLISH : ST_SCAN;
        end
      end
      ST_SAR: begin
        if (sar_bit == 5'd0) begin
          next_work[O_CHAN_SEL] = fmt;
          next_dac   = 18'h0;
          next_chan  = O_CHAN_SEL + 3'h1;
          next_state = (O_CHAN_SEL == 3'h7) ? ST_PUBLISH : ST_SCAN;
        end else begin
          next_dac     = kept | (18'h1 << (sar_bit - 5'd1));
          next_sar_bit = sar_bit - 5'd1;
        end
      end
      ST_PUBLISH: begin
        next_result = work;
        next_hold   = 1'b0;
        next_chan   = 3'h0;
        next_state  = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      ctrl_reg                 <= `CTRL_RESET;
      range_word               <= `RANGE_RESET;
      conv_range               <= `RANGE_RESET;
      state                    <= ST_IDLE;
      sar_bit                  <= 5'd0;
      O_CHAN_SEL               <= 3'h0;
      O_CAP_REDISTRIBUTION_DAC <= 18'h0;
      O_HOLD                   <= 1'b0;
      O_BUSY                   <= 1'b0;
      O_LANES                  <= 4'h8;
      O_POWER_DOWN             <= 1'b0;
      for (int i = 0; i < `NUM_CHANNELS; i++) begin
        work[i]   <= 18'h0;
        result[i] <= 18'h0;
      end
    end else begin
      ctrl_reg                 <= next_ctrl_reg;
      range_word               <= next_range_word;
      conv_range               <= next_conv_range;
      state                    <= next_state;
      sar_bit                  <= next_sar_bit;
      O_CHAN_SEL               <= next_chan;
      O_CAP_REDISTRIBUTION_DAC <= next_dac;
      O_HOLD                   <= next_hold;
      O_BUSY                   <= (next_state != ST_IDLE);
      O_LANES                  <= {1'b0, next_ctrl_reg[6:4]} + 4'h1;
      O_POWER_DOWN             <= next_ctrl_reg[`CTRL_PD_BIT];
      work                     <= next_work;
      result                   <= next_result;
    end
  end

  //--------------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------------
  property p_start_holds;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_IDLE && start_rise && !ctrl_reg[0]) |=> (O_HOLD && O_BUSY && O_CHAN_SEL == 3'h0);
  endproperty
  a_start_holds: assert property (p_start_holds) else $error("start edge did not hold");

  property p_one_channel;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_SAR && sar_bit != 5'd0) |=> $stable(O_CHAN_SEL) && O_HOLD;
  endproperty
  a_one_channel: assert property (p_one_channel) else $error("channel moved mid search");

  property p_eighteen_steps;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_SCAN && cur_en) |=> O_CAP_REDISTRIBUTION_DAC == 18'h20000
      ##17 (state == ST_SAR && sar_bit == 5'd0);
  endproperty
  a_eighteen_steps: assert property (p_eighteen_steps) else $error("search not 18 steps");

  property p_publish_only;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state != ST_PUBLISH) |=> $stable(result[0]) && $stable(result[7]);
  endproperty
  a_publish_only: assert property (p_publish_only) else $error("results changed early");

  property p_bipolar_format;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_SAR && sar_bit == 5'd0 && is_bipolar(cur_range))
      |=> work[$past(O_CHAN_SEL)][17] != $past(kept[17]);
  endproperty
  a_bipolar_format: assert property (p_bipolar_format) else $error("bipolar sign wrong");

  property p_unipolar_format;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_SAR && sar_bit == 5'd0 && cur_en && !is_bipolar(cur_range))
      |=> work[$past(O_CHAN_SEL)] == $past(kept);
  endproperty
  a_unipolar_format: assert property (p_unipolar_format) else $error("unipolar code wrong");

  property p_range_frozen;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state != ST_IDLE) |=> $stable(conv_range);
  endproperty
  a_range_frozen: assert property (p_range_frozen) else $error("range changed mid run");

  property p_skip_disabled;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_SCAN && !cur_en) |=> state != ST_SAR && work[$past(O_CHAN_SEL)] == 18'h0;
  endproperty
  a_skip_disabled: assert property (p_skip_disabled) else $error("disabled channel ran");

  property p_strap_static;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    strap_done |=> $stable(O_LVDS_MODE);
  endproperty
  a_strap_static: assert property (p_strap_static) else $error("port style changed");

  property p_power_down;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_IDLE && ctrl_reg[0]) |=> state == ST_IDLE;
  endproperty
  a_power_down: assert property (p_power_down) else $error("converted in power down");

  property p_busy_ignore;
    @(posedge I_CLOCK) disable iff (!I_NRST)
    (state == ST_SAR && start_rise && sar_bit != 5'd0) |=> state == ST_SAR && O_BUSY;
  endproperty
  a_busy_ignore: assert property (p_busy_ignore) else $error("start not ignored");

endmodule : sar_conv_ctrl

// file: inc/sar_ctrl_params.svh
// offsets, field positions and reset values of the conversion controller
`ifndef SAR_CTRL_PARAMS_SVH
`define SAR_CTRL_PARAMS_SVH
`define ADDR_CTRL        8'h00
`define ADDR_RANGE       8'h04
`define ADDR_STATUS      8'h08
`define ADDR_RESULT0     8'h20
`define ADDR_RESULT_LAST 8'h3C
`define CTRL_PD_BIT      0
`define CTRL_LANES_LSB   4
`define CTRL_LANES_MSB   6
`define CTRL_RESET       32'h0000_0070
`define RANGE_RESET      24'hFFFFFF
`define RESULT_BITS      18
`define RANGE_BITS       3
`define NUM_CHANNELS     8
`define DAC_MSB_CODE     18'h20000
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

// file: inc/sar_ctrl_pkg.sv
// types shared by the conversion controller
package sar_ctrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_SAR, ST_PUBLISH} conv_state_t;
  typedef logic [2:0]  range_code_t;
  typedef logic [17:0] result_t;
  typedef logic [31:0] axi_data_t;
  typedef logic [7:0]  axi_addr_t;

  // codes 7, 6, 3, 2 are bipolar spans
  function automatic logic is_bipolar(input range_code_t code);
    return (code == 3'h7) || (code == 3'h6) || (code == 3'h3) || (code == 3'h2);
  endfunction : is_bipolar
endpackage : sar_ctrl_pkg

// file: testbench/analog_front_model.sv
// track-and-hold and comparator model of the eight analog channels
`timescale 1ns/1ps

module analog_front_model (
  // clock
  input  wire logic                  i_clock,
  // analog levels of the eight channels, channel n at bits 18n+17:18n
  input  wire logic [143:0]          i_level,
  // converter side
  input  wire logic                  i_hold,
  input  wire logic [2:0]            i_chan_sel,
  input  wire sar_ctrl_pkg::result_t i_dac,
  output logic                       o_above
);
  import sar_ctrl_pkg::*;

  result_t held [8];

  // ----------------------------------------
  // tracking while released, frozen in hold
  // ----------------------------------------
  always_ff @(posedge i_clock) begin
    for (int n = 0; n < 8; n++) begin
      if (!i_hold) begin
        held[n] <= i_level[n*18 +: 18];
      end
    end
  end

  // only the selected channel reaches the comparator
  assign o_above = (held[i_chan_sel] >= i_dac);
endmodule : analog_front_model

// file: testbench/sar_conv_ctrl_tb.sv
// self-checking bench of the conversion controller
`timescale 1ns/1ps
`include "sar_ctrl_params.svh"

module sar_conv_ctrl_tb;
  import sar_ctrl_pkg::*;

  logic         clock = 1'b0;
  logic         nrst = 1'b0;
  logic         start = 1'b0;
  logic         strap = 1'b1;
  logic [143:0] level = '0;
  logic         comp, hold, busy, lvds, pd;
  logic [2:0]   chan;
  result_t      dac;
  logic [3:0]   lanes;
  axi_addr_t    awaddr = '0;
  axi_addr_t    araddr = '0;
  axi_data_t    wdata = '0;
  axi_data_t    rdata;
  logic [3:0]   wstrb = 4'hF;
  logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  int           errors = 0;
  int           checked = 0;
  axi_data_t    d, word;
  logic [1:0]   r;
  int           c1, c2;

  always #10 clock = ~clock;

  sar_conv_ctrl u_sar_conv_ctrl (
    .I_CLOCK(clock), .I_NRST(nrst), .I_CONVERT_START(start), .I_LVDS_STRAP(strap),
    .I_COMP_ABOVE(comp), .O_HOLD(hold), .O_BUSY(busy), .O_CHAN_SEL(chan),
    .O_CAP_REDISTRIBUTION_DAC(dac), .O_LVDS_MODE(lvds), .O_LANES(lanes), .O_POWER_DOWN(pd),
    .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata),
    .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
    .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
    .I_RREADY(rready));

  analog_front_model u_analog_front_model (
    .i_clock(clock), .i_level(level), .i_hold(hold), .i_chan_sel(chan), .i_dac(dac),
    .o_above(comp));

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic end_sim;
    if (errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic give_up(input string name);
    errors++;
    $display("[ERR] %s expected handshake seen timeout", name);
    end_sim();
  endtask : give_up

  function automatic result_t expected_code(input range_code_t c, input result_t v);
    case (c)
      3'h0: return '0;
      3'h7, 3'h6, 3'h3, 3'h2: return v ^ 18'h20000;
      default: return v;
    endcase
  endfunction : expected_code

  // ----------------------------------------
  // bus master
  // ----------------------------------------
  task automatic axi_write(input axi_addr_t a, input axi_data_t v, output logic [1:0] resp);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clock);
      n++;
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      if (n > 50) give_up("write address or data");
    end
    do begin
      @(posedge clock);
      n++;
      if (n > 100) give_up("write response");
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input axi_addr_t a, output axi_data_t v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      n++;
      if (n > 50) give_up("read address");
    end while (arready !== 1'b1);
    arvalid <= 1'b0;
    do begin
      @(posedge clock);
      n++;
      if (n > 100) give_up("read data");
    end while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  // ----------------------------------------
  // conversion and result readout
  // ----------------------------------------
  task automatic convert(input logic retrig, output int cycles);
    int n;
    n = 0;
    cycles = 0;
    @(posedge clock);
    start <= 1'b1;
    repeat (4) @(posedge clock);
    start <= 1'b0;
    while (busy !== 1'b1) begin
      @(posedge clock);
      n++;
      if (n > 20) give_up("busy rise");
    end
    chk("hold at start", 32'h1, {31'h0, hold});
    while (busy === 1'b1) begin
      @(posedge clock);
      cycles++;
      if (retrig && cycles == 40) start <= 1'b1;
      if (retrig && cycles == 45) start <= 1'b0;
      if (cycles > 400) give_up("busy fall");
    end
    chk("hold at end", 32'h0, {31'h0, hold});
  endtask : convert

  task automatic check_results(input axi_data_t rng);
    for (int n = 0; n < 8; n++) begin
      axi_read(axi_addr_t'(`ADDR_RESULT0 + 4 * n), d, r);
      chk($sformatf("result%0d", n), {14'h0, expected_code(rng[3*n +: 3], level[n*18 +: 18])},
          d);
    end
  endtask : check_results

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    chk("lanes reset", 32'h8, {28'h0, lanes});
    chk("strap", 32'h1, {31'h0, lvds});
    axi_read(`ADDR_CTRL, d, r);
    chk("ctrl reset", `CTRL_RESET, d);
    axi_read(`ADDR_RANGE, d, r);
    chk("range reset", {8'h0, `RANGE_RESET}, d);
    axi_read(`ADDR_STATUS, d, r);
    chk("status", 32'h2, d);
    axi_write(8'h10, 32'hFFFF_FFFF, r);
    chk("unmapped write resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    axi_read(8'h10, d, r);
    chk("unmapped read resp", {30'h0, `RESP_SLVERR}, {30'h0, r});
    chk("unmapped read data", 32'h0, d);
    axi_write(`ADDR_CTRL, 32'h0, r);
    chk("one lane", 32'h1, {28'h0, lanes});
    axi_write(`ADDR_CTRL, 32'h30, r);
    chk("four lanes", 32'h4, {28'h0, lanes});
    axi_read(`ADDR_CTRL, d, r);
    chk("ctrl readback", 32'h30, d);
    // channel n on range code n, boundary levels on channels 1 and 7
    word = '0;
    for (int n = 0; n < 8; n++) begin
      word[3*n +: 3] = 3'(n);
      level[n*18 +: 18] <= (n == 1) ? 18'h0 : (n == 7) ? 18'h3FFFF : 18'(32'h0B3C5 * (n + 1));
    end
    axi_write(`ADDR_RANGE, word, r);
    axi_read(`ADDR_RANGE, d, r);
    chk("range word", word, d);
    wstrb <= 4'h1;
    axi_write(`ADDR_RANGE, 32'h0, r);
    wstrb <= 4'hF;
    axi_read(`ADDR_RANGE, d, r);
    chk("range byte strobe", {word[31:8], 8'h00}, d);
    axi_write(`ADDR_RANGE, word, r);
    convert(1'b1, c1);
    repeat (12) @(posedge clock);
    chk("late start ignored", 32'h0, {31'h0, busy});
    check_results(word);
    axi_write(`ADDR_RESULT0, 32'h15555, r);
    chk("result write resp", {30'h0, `RESP_OKAY}, {30'h0, r});
    axi_read(`ADDR_RESULT0, d, r);
    chk("result read only", 32'h0, d);
    // all channels unipolar full scale on the next conversion
    word = 32'h00B6_DB6D;
    for (int n = 0; n < 8; n++) begin
      level[n*18 +: 18] <= (n == 0) ? 18'h3FFFF : 18'(32'h1D2B7 * (n + 3));
    end
    axi_write(`ADDR_RANGE, word, r);
    convert(1'b0, c2);
    check_results(word);
    chk("cycles per disabled channel", 32'd18, 32'(c2 - c1));
    axi_write(`ADDR_CTRL, 32'h71, r);
    chk("power down", 32'h1, {31'h0, pd});
    start <= 1'b1;
    repeat (4) @(posedge clock);
    start <= 1'b0;
    repeat (8) @(posedge clock);
    chk("no conversion in power down", 32'h0, {31'h0, busy});
    axi_write(`ADDR_CTRL, 32'h70, r);
    chk("power up", 32'h0, {31'h0, pd});
    strap <= 1'b0;
    repeat (4) @(posedge clock);
    chk("strap static", 32'h1, {31'h0, lvds});
    end_sim();
  end
endmodule : sar_conv_ctrl_tb
